// ### core/fes_pkg.sv
// package for the flash erase/reset host controller
// assumes a 20 MHz sys_clk and an asynchronous parallel flash on the pins
package fes_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int LOAD_WIN_US = 50;
	localparam int LOAD_WIN_CYC = (LOAD_WIN_US * CLK_HZ) / 1000000;
	localparam int POLL_LIMIT = 1000000;
	localparam int TW = 20;
	// ----------------------------------------
	// flash bus widths and command codes
	// ----------------------------------------
	localparam int AW = 18;
	localparam int DW = 16;
	localparam logic [AW-1:0] UNLOCK_ADDR1 = 18'h00555;
	localparam logic [AW-1:0] UNLOCK_ADDR2 = 18'h002aa;
	localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
	localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
	localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] PROT_YES = 8'h01;
	localparam logic [7:0] PROT_NO = 8'h00;
	// ----------------------------------------
	// status bit positions in read data
	// ----------------------------------------
	localparam int BIT_POLL = 7;
	localparam int BIT_TOG1 = 6;
	localparam int BIT_TIMEOUT = 5;
	localparam int BIT_EWIN = 3;
	localparam int BIT_TOG2 = 2;
	// ----------------------------------------
	// software register map (word index on the address port)
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_RDATA = 4'h3;
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam logic [31:0] STATUS_RESET = 32'h0;
	// ----------------------------------------
	// operations
	// ----------------------------------------
	typedef enum logic [2:0] {
		FES_OP_READ = 3'h0,
		FES_OP_CHIP_ERASE = 3'h1,
		FES_OP_BLOCK_ERASE = 3'h2,
		FES_OP_ADD_BLOCK = 3'h3,
		FES_OP_RESET = 3'h4,
		FES_OP_ID_READ = 3'h5,
		FES_OP_SUSPEND = 3'h6
	} fes_op_e;
endpackage

// ### core/fes_cyc_if.sv
// interface between the sequencer and the bus cycle engine
// assumes one clock domain, sys_clk
`timescale 1ns/10ps
interface fes_cyc_if;
	import fes_pkg::*;
	logic req;
	logic wr;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic done;
	logic [DW-1:0] rdata;
	modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ### core/fes_sync.sv
// three-flop synchroniser with agreement filter for a pin input
// assumes the input is asynchronous to sys_clk
`timescale 1ns/10ps
module fes_sync #(parameter int W = 1) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// data
	input wire logic [W-1:0] pin,
	output logic [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire logic [W-1:0] agree = ~(s2 ^ s3);
	wire logic [W-1:0] next_q = (agree & s2) | (~agree & q);
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end
endmodule

// ### core/fes_cycle.sv
// one flash bus cycle: write strobe pulse or read with output enable
// assumes flash read data is stable STROBE_CYC cycles after oe_n falls
`timescale 1ns/10ps
module fes_cycle (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// sequencer side
	fes_cyc_if.eng cyc,
	// flash pins
	output logic [fes_pkg::AW-1:0] f_addr,
	output logic [fes_pkg::DW-1:0] f_dq_out,
	output logic f_dq_oe,
	input wire logic [fes_pkg::DW-1:0] f_dq_in,
	output logic f_ce_n,
	output logic f_we_n,
	output logic f_oe_n
);
	import fes_pkg::*;
	// ----------------------------------------
	// phases: setup, strobe low, recovery
	// ----------------------------------------
	typedef enum logic [3:0] {
		FES_C_IDLE = 4'b0001,
		FES_C_SET = 4'b0010,
		FES_C_LOW = 4'b0100,
		FES_C_REC = 4'b1000
	} fes_cph_e;
	fes_cph_e st;
	logic [7:0] cnt;
	logic is_wr;
	logic done_r;
	logic [DW-1:0] rd_r;
	wire logic cnt_end = (cnt == 8'(STROBE_CYC - 1));
	assign cyc.done = done_r;
	assign cyc.rdata = rd_r;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= FES_C_IDLE;
			cnt <= 8'h0;
			is_wr <= 1'b0;
			done_r <= 1'b0;
			rd_r <= '0;
			f_addr <= '0;
			f_dq_out <= '0;
			f_dq_oe <= 1'b0;
			f_ce_n <= 1'b1;
			f_we_n <= 1'b1;
			f_oe_n <= 1'b1;
		end else begin
			done_r <= 1'b0;
			case (st)
				FES_C_IDLE: begin
					if (cyc.req) begin
						// address held through the falling edge, data through the rising edge
						f_addr <= cyc.addr;
						f_dq_out <= cyc.wdata;
						f_dq_oe <= cyc.wr;
						is_wr <= cyc.wr;
						f_ce_n <= 1'b0;
						cnt <= 8'h0;
						st <= FES_C_SET;
					end
				end
				FES_C_SET: begin
					f_we_n <= ~is_wr;
					f_oe_n <= is_wr;
					st <= FES_C_LOW;
				end
				FES_C_LOW: begin
					cnt <= cnt + 8'h1;
					if (cnt_end) begin
						rd_r <= f_dq_in;
						// we_n rises before ce_n, so it is the edge that latches
						f_we_n <= 1'b1;
						f_oe_n <= 1'b1;
						st <= FES_C_REC;
					end
				end
				FES_C_REC: begin
					f_ce_n <= 1'b1;
					f_dq_oe <= 1'b0;
					done_r <= 1'b1;
					st <= FES_C_IDLE;
				end
				default: st <= FES_C_IDLE;
			endcase
		end
	end
endmodule

// ### core/fes_host.sv
// host controller that drives a parallel nor flash for erase, reset and id reads
// assumes a software port on sys_clk; read data stands one cycle after the read strobe
`timescale 1ns/10ps
module fes_host (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// software port
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	// flash pins
	output logic [fes_pkg::AW-1:0] f_addr,
	output logic [fes_pkg::DW-1:0] f_dq_out,
	output logic f_dq_oe,
	input wire logic [fes_pkg::DW-1:0] f_dq_in,
	output logic f_ce_n,
	output logic f_we_n,
	output logic f_oe_n,
	input wire logic ready_busy_n
);
	import fes_pkg::*;
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [6:0] {
		FES_S_IDLE = 7'b0000001,
		FES_S_WRITE = 7'b0000010,
		FES_S_POLL_A = 7'b0000100,
		FES_S_POLL_B = 7'b0001000,
		FES_S_READ = 7'b0010000,
		FES_S_RST = 7'b0100000,
		FES_S_DONE = 7'b1000000
	} fes_state_e;
	fes_state_e st;
	fes_cyc_if cyc();
	logic rb_sync;
	logic [2:0] op;
	logic [AW-1:0] target;
	logic [2:0] step;
	logic [2:0] last_step;
	logic poll_after;
	logic busy;
	logic done_ok;
	logic timeout_err;
	logic poll_fail;
	logic win_open;
	logic id_active;
	logic [DW-1:0] first_rd;
	logic [DW-1:0] last_rd;
	logic [31:0] poll_cnt;
	logic [11:0] win_cnt;
	logic req_r;
	// one request per bus cycle; the engine only looks at req while idle
	logic in_flight;
	logic wr_r;
	logic [AW-1:0] cyc_addr;
	logic [DW-1:0] cyc_wdata;
	// ----------------------------------------
	// command step table
	// ----------------------------------------
	function automatic logic [AW+7:0] step_word(input logic [2:0] o, input logic [2:0] s,
			input logic [AW-1:0] tgt);
		logic [7:0] last_code;
		last_code = (o == FES_OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_BLOCK_ERASE;
		case (s)
			3'd0: step_word = {UNLOCK_ADDR1, UNLOCK_DATA1};
			3'd1: step_word = {UNLOCK_ADDR2, UNLOCK_DATA2};
			3'd2: step_word = (o == FES_OP_ID_READ) ? {UNLOCK_ADDR1, CMD_ID_ENTRY}
				: {UNLOCK_ADDR1, CMD_ERASE_SETUP};
			3'd3: step_word = {UNLOCK_ADDR1, UNLOCK_DATA1};
			3'd4: step_word = {UNLOCK_ADDR2, UNLOCK_DATA2};
			3'd5: step_word = (o == FES_OP_CHIP_ERASE) ? {UNLOCK_ADDR1, last_code}
				: {tgt, last_code};
			default: step_word = {UNLOCK_ADDR1, CMD_RESET};
		endcase
	endfunction
	// ----------------------------------------
	// software decode
	// ----------------------------------------
	wire logic go = sw_wr && (sw_addr == REG_CTRL) && sw_wdata[CTRL_GO] && !busy;
	wire logic [2:0] go_op = sw_wdata[CTRL_OP_LSB +: 3];
	// any op, reset included, needs busy clear; add-block and suspend also need the load window, all others do not
	wire logic add_ok = (go_op != FES_OP_ADD_BLOCK && go_op != FES_OP_SUSPEND) || win_open;
	wire logic [2:0] go_first = (go_op == FES_OP_ADD_BLOCK) ? 3'd5
		: (go_op == FES_OP_SUSPEND || go_op == FES_OP_RESET) ? 3'd6
		: (go_op == FES_OP_READ) ? 3'd7 : 3'd0;
	wire logic [2:0] go_last = (go_op == FES_OP_ID_READ) ? 3'd2
		: (go_op == FES_OP_RESET || go_op == FES_OP_SUSPEND) ? 3'd6 : 3'd5;
	wire logic [AW+7:0] cur_step = step_word(op, step, target);
	wire logic [7:0] suspend_code = CMD_SUSPEND;
	wire logic [DW-1:0] next_wdata = (op == FES_OP_SUSPEND) ? {8'h0, suspend_code}
		: {8'h0, cur_step[7:0]};
	wire logic [AW-1:0] next_addr = (op == FES_OP_SUSPEND) ? target : cur_step[AW+7:8];
	wire logic is_erase = (op == FES_OP_CHIP_ERASE) || (op == FES_OP_BLOCK_ERASE);
	// toggle steady across two back-to-back reads means finished
	wire logic tog_same = (first_rd[BIT_TOG1] == cyc.rdata[BIT_TOG1]);
	wire logic poll_one = cyc.rdata[BIT_POLL];
	wire logic tmo_seen = cyc.rdata[BIT_TIMEOUT] && !tog_same;
	wire logic [31:0] status_word = {16'h0, last_rd[7:0], 1'b0, ~rb_sync, win_open, id_active,
		poll_fail, timeout_err, done_ok, busy};
	wire logic [31:0] next_sw_rdata = !sw_rd ? 32'h0
		: (sw_addr == REG_STATUS) ? status_word
		: (sw_addr == REG_ADDR) ? {14'h0, target}
		: (sw_addr == REG_RDATA) ? {16'h0, last_rd}
		: 32'h0;
	assign cyc.req = req_r;
	assign cyc.wr = wr_r;
	assign cyc.addr = cyc_addr;
	assign cyc.wdata = cyc_wdata;
	fes_sync #(.W(1)) u_rb_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin(ready_busy_n),
		.q(rb_sync)
	);
	fes_cycle u_cycle (
		.sys_clk(sys_clk),
		.reset(reset),
		.cyc(cyc.eng),
		.f_addr(f_addr),
		.f_dq_out(f_dq_out),
		.f_dq_oe(f_dq_oe),
		.f_dq_in(f_dq_in),
		.f_ce_n(f_ce_n),
		.f_we_n(f_we_n),
		.f_oe_n(f_oe_n)
	);
	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sw_rdata <= STATUS_RESET;
			target <= '0;
		end else begin
			sw_rdata <= next_sw_rdata;
			if (sw_wr && sw_addr == REG_ADDR) begin
				target <= sw_wdata[AW-1:0];
			end
		end
	end
	// ----------------------------------------
	// load window timer
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			win_cnt <= 12'h0;
			win_open <= 1'b0;
		end else if (st == FES_S_WRITE && cyc.done && step == 3'd5 && op != FES_OP_CHIP_ERASE) begin
			// margin of four strobes keeps the next falling edge inside the window
			win_cnt <= 12'(LOAD_WIN_CYC - 4 * STROBE_CYC);
			win_open <= 1'b1;
		end else if (go && go_op != FES_OP_ADD_BLOCK) begin
			win_open <= 1'b0;
		end else if (win_cnt != 12'h0) begin
			win_cnt <= win_cnt - 12'h1;
		end else begin
			win_open <= 1'b0;
		end
	end
	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= FES_S_IDLE;
			op <= 3'h0;
			step <= 3'h0;
			last_step <= 3'h0;
			poll_after <= 1'b0;
			busy <= 1'b0;
			done_ok <= 1'b0;
			timeout_err <= 1'b0;
			poll_fail <= 1'b0;
			id_active <= 1'b0;
			first_rd <= '0;
			last_rd <= '0;
			poll_cnt <= 32'h0;
			req_r <= 1'b0;
			in_flight <= 1'b0;
			wr_r <= 1'b0;
			cyc_addr <= '0;
			cyc_wdata <= '0;
		end else begin
			req_r <= 1'b0;
			case (st)
				FES_S_IDLE: begin
					if (go && add_ok) begin
						op <= go_op;
						step <= go_first;
						last_step <= go_last;
						busy <= 1'b1;
						done_ok <= 1'b0;
						poll_fail <= 1'b0;
						// resets clear the timeout state and leave id mode
						if (go_op == FES_OP_RESET) begin
							timeout_err <= 1'b0;
						end
						st <= (go_op == FES_OP_READ) ? FES_S_READ : FES_S_WRITE;
						poll_after <= (go_op == FES_OP_ADD_BLOCK) || (go_op == FES_OP_CHIP_ERASE);
					end
				end
				FES_S_WRITE: begin
					if (!in_flight && !cyc.done) begin
						req_r <= 1'b1;
						in_flight <= 1'b1;
						wr_r <= 1'b1;
						cyc_addr <= next_addr;
						cyc_wdata <= next_wdata;
					end
					if (cyc.done) begin
						in_flight <= 1'b0;
						if (step == last_step) begin
							id_active <= (op == FES_OP_ID_READ);
							// block erase waits for more loads; polling follows later
							st <= poll_after ? FES_S_POLL_A : FES_S_DONE;
							poll_cnt <= 32'h0;
						end else begin
							step <= step + 3'd1;
						end
					end
				end
				FES_S_READ, FES_S_POLL_A, FES_S_POLL_B: begin
					if (!in_flight && !cyc.done) begin
						req_r <= 1'b1;
						in_flight <= 1'b1;
						wr_r <= 1'b0;
						// id reads use addr bits one and zero; polls use the erase target
						cyc_addr <= target;
					end
					if (cyc.done) begin
						in_flight <= 1'b0;
						last_rd <= cyc.rdata;
						if (st == FES_S_READ) begin
							st <= FES_S_DONE;
						end else if (st == FES_S_POLL_A) begin
							first_rd <= cyc.rdata;
							st <= FES_S_POLL_B;
						end else if (tog_same || poll_one) begin
							st <= FES_S_DONE;
						end else if (tmo_seen) begin
							// the flash accepts nothing but reset now; software must send one
							timeout_err <= 1'b1;
							poll_fail <= 1'b1;
							st <= FES_S_DONE;
						end else if (poll_cnt == 32'(POLL_LIMIT)) begin
							poll_fail <= 1'b1;
							st <= FES_S_DONE;
						end else begin
							poll_cnt <= poll_cnt + 32'h1;
							st <= FES_S_POLL_A;
						end
					end
				end
				FES_S_DONE: begin
					busy <= 1'b0;
					done_ok <= !poll_fail;
					if (op == FES_OP_RESET) begin
						id_active <= 1'b0;
					end
					st <= FES_S_IDLE;
				end
				default: st <= FES_S_IDLE;
			endcase
		end
	end
endmodule

// ### verification/fes_host_asserts.sv
// checker for the fes_host pin and software port timing
// assumes it is bound onto fes_host and sees only its ports
`timescale 1ns/10ps
module fes_host_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// software port
	input wire logic sw_rd,
	input wire logic [31:0] sw_rdata,
	// flash pins
	input wire logic [fes_pkg::AW-1:0] f_addr,
	input wire logic [fes_pkg::DW-1:0] f_dq_out,
	input wire logic f_dq_oe,
	input wire logic f_ce_n,
	input wire logic f_we_n,
	input wire logic f_oe_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// flash cycle shape
	// ----------------------------------------
	strobe_excl_a: assert property (f_we_n || f_oe_n) else $error("write and read strobes low together");
	we_in_ce_a: assert property (!f_we_n |-> !f_ce_n) else $error("write strobe outside chip select");
	setup_first_a: assert property ($fell(f_ce_n) |=> $fell(f_we_n) || $fell(f_oe_n))
		else $error("strobe did not follow chip select");
	we_width_a: assert property ($fell(f_we_n) |-> ##1 !f_we_n ##1 f_we_n) else $error("write pulse width");
	oe_width_a: assert property ($fell(f_oe_n) |-> ##1 !f_oe_n ##1 f_oe_n) else $error("read pulse width");
	dq_drive_a: assert property (!f_we_n |-> f_dq_oe && $stable(f_dq_out)) else $error("write data not held");
	read_float_a: assert property (!f_oe_n |-> !f_dq_oe) else $error("data driven during read");
	addr_hold_a: assert property (!f_ce_n && $past(!f_ce_n) |-> $stable(f_addr))
		else $error("address moved in a cycle");
	cmd_byte_a: assert property (!f_we_n |-> f_dq_out[15:8] == 8'h00) else $error("command upper byte");
	ce_release_a: assert property ($rose(f_we_n) || $rose(f_oe_n) |=> f_ce_n && !f_dq_oe)
		else $error("chip select not released");
	rdata_idle_a: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0) else $error("read data outside slot");
	// ----------------------------------------
	// coverage
	// ----------------------------------------
	write_seen_c: cover property ($fell(f_we_n));
	read_seen_c: cover property ($fell(f_oe_n));
	reg_read_c: cover property (sw_rd ##1 sw_rdata != 32'h0);
endmodule
bind fes_host fes_host_asserts i_fes_host_asserts (.sys_clk(sys_clk), .reset(reset), .sw_rd(sw_rd),
	.sw_rdata(sw_rdata), .f_addr(f_addr), .f_dq_out(f_dq_out), .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n),
	.f_we_n(f_we_n), .f_oe_n(f_oe_n));

// ### verification/fes_flash_model.sv
// behavioural parallel nor flash: erase, reset and id command decoding
// assumes strobes from fes_host; ready/busy is resolved with a pull-up by the bench
`timescale 1ns/10ps
module fes_flash_model #(
	parameter logic [15:0] MAKER_ID = 16'h005a, // arbitrary
	parameter logic [15:0] PART_ID = 16'h1234, // arbitrary
	parameter int BUSY_READS = 6,
	parameter real WIN_NS = 50000.0
) (
	input wire logic [17:0] f_addr,
	input wire logic [15:0] f_dq_out,
	input wire logic f_ce_n,
	input wire logic f_we_n,
	input wire logic f_oe_n,
	input wire logic force_to,
	output logic [15:0] f_dq_in,
	output logic rb_low
);
	// mode 0 array, 1 id, 2 load window, 3 erasing; erase time counts status reads
	logic [63:0] erased = '0, pend = '0, prot = 64'h8;
	int step = 0, mode = 0, left = 0;
	logic tog = 0, tmo = 0;
	logic [17:0] wa;
	realtime t_last = 0;
	assign rb_low = (mode == 3);
	initial f_dq_in = 16'h0;
	task expire;
		if (mode == 2 && $realtime - t_last > WIN_NS) begin
			mode = 3;
			left = BUSY_READS;
		end
	endtask
	always @(negedge f_we_n) if (!f_ce_n) begin
		wa = f_addr;
		expire;
	end
	always @(posedge f_we_n) if (!f_ce_n) begin
		logic [7:0] d;
		logic ok;
		d = f_dq_out[7:0];
		if (mode == 3) begin
			if (d == 8'hf0 && tmo) begin
				mode = 0;
				tmo = 0;
				pend = '0;
			end
		end else if (d == 8'hf0) begin
			mode = 0;
			step = 0;
			pend = '0;
		end else if (mode == 2) begin
			if (d == 8'h30) pend[wa[17:12]] = 1'b1;
			else mode = 0;
			t_last = $realtime;
		end else begin
			case (step)
				0, 3: ok = wa == 18'h555 && d == 8'haa;
				1, 4: ok = wa == 18'h2aa && d == 8'h55;
				2: ok = wa == 18'h555 && (d == 8'h80 || d == 8'h90);
				default: ok = d == 8'h10 || d == 8'h30;
			endcase
			step = ok ? step + 1 : 0;
			if (step == 3 && d == 8'h90) begin
				mode = 1;
				step = 0;
			end
			if (step == 6) begin
				step = 0;
				t_last = $realtime;
				if (d == 8'h10) begin
					pend = '1;
					mode = 3;
					left = BUSY_READS;
				end else begin
					pend[wa[17:12]] = 1'b1;
					mode = 2;
				end
			end
		end
	end
	always @(negedge f_oe_n) if (!f_ce_n) begin
		expire;
		tog = ~tog;
		if (mode == 3) tmo = tmo | force_to;
		case (mode)
			1: f_dq_in = f_addr[1] ? {15'h0, prot[f_addr[17:12]]} : (f_addr[0] ? PART_ID : MAKER_ID);
			2, 3: f_dq_in = {8'h0, 1'b0, tog, tmo, 1'b0, mode == 3, tog, 2'b0};
			default: f_dq_in = erased[f_addr[17:12]] ? 16'hffff : f_addr[15:0] ^ 16'h0f0f;
		endcase
		if (mode == 3 && !tmo) left = left - 1;
		if (mode == 3 && left == 0) begin
			erased = erased | pend;
			pend = '0;
			mode = 0;
		end
	end
	// a released bus must not keep showing the last value
	always @(posedge f_oe_n) f_dq_in = ~f_dq_in;
endmodule

// ### verification/fes_host_bench.sv
// self-checking bench for fes_host against the behavioural flash
// assumes fes_pkg and fes_flash_model; ready/busy has a pull-up
`timescale 1ns/10ps
module fes_host_bench;
	import fes_pkg::*;
	typedef struct {logic [17:0] a; logic [31:0] e;} fes_row_s;
	localparam logic [15:0] MK = 16'h005a;
	localparam logic [15:0] PT = 16'h1234;
	logic sys_clk = 0, reset = 1, sw_wr = 0, sw_rd = 0, force_to = 0, rb_low;
	logic [3:0] sw_addr = '0;
	logic [31:0] sw_wdata = '0, sw_rdata, st;
	logic [AW-1:0] f_addr;
	logic [DW-1:0] f_dq_out, f_dq_in;
	logic f_dq_oe, f_ce_n, f_we_n, f_oe_n;
	wire ready_busy_n = rb_low ? 1'b0 : 1'b1;
	int miscompares = 0, n_compared = 0;
	fes_row_s rows[4] = '{'{18'h00000, {16'h0, MK}}, '{18'h00001, {16'h0, PT}}, '{18'h03003, 32'h1},
		'{18'h05002, 32'h0}};
	fes_host i_fes_host (.sys_clk(sys_clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .f_addr(f_addr), .f_dq_out(f_dq_out),
		.f_dq_oe(f_dq_oe), .f_dq_in(f_dq_in), .f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n),
		.ready_busy_n(ready_busy_n));
	fes_flash_model #(.MAKER_ID(MK), .PART_ID(PT)) i_fes_flash_model (.f_addr(f_addr), .f_dq_out(f_dq_out),
		.f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n), .force_to(force_to), .f_dq_in(f_dq_in),
		.rb_low(rb_low));
	initial forever #25 sys_clk = ~sys_clk;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		#1 st = sw_rdata;
	endtask
	// busy is polled under a bound; a hang shows as a mismatch
	task op(input logic [2:0] o, input logic [17:0] a);
		wr(REG_ADDR, {14'h0, a});
		wr(REG_CTRL, {28'h0, o, 1'b1});
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 8000; i++) begin
			rd(REG_STATUS);
			if (st[0] === 1'b0) break;
		end
		if (st[0] !== 1'b0) chk(st, 32'h0);
	endtask
	task rd_flash(input logic [17:0] a, input logic [31:0] e);
		op(FES_OP_READ, a);
		rd(REG_RDATA);
		chk(st, e);
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#(90000 * 50);
		miscompares++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		op(FES_OP_ID_READ, 18'h0);
		foreach (rows[i]) rd_flash(rows[i].a, rows[i].e);
		$display("id table done");
		rd(REG_STATUS);
		chk(st & 32'h10, 32'h10);
		op(FES_OP_RESET, 18'h0);
		rd_flash(18'h00001, 32'h0f0e);
		rd(4'hf);
		chk(st, 32'h0);
		$display("reset test done");
		@(posedge sys_clk) force_to <= 1'b1;
		op(FES_OP_CHIP_ERASE, 18'h0);
		rd(REG_STATUS);
		chk(st & 32'h6, 32'h4);
		chk(st & 32'h40, 32'h40);
		@(posedge sys_clk) force_to <= 1'b0;
		op(FES_OP_RESET, 18'h0);
		rd(REG_STATUS);
		chk(st & 32'h4, 32'h0);
		rd_flash(18'h00002, 32'h0f0d);
		$display("timeout test done");
		op(FES_OP_BLOCK_ERASE, 18'h05000);
		rd(REG_STATUS);
		chk(st & 32'h20, 32'h20);
		op(FES_OP_ADD_BLOCK, 18'h07000);
		rd_flash(18'h05010, 32'hffff);
		rd_flash(18'h07010, 32'hffff);
		rd_flash(18'h06010, 32'h6f1f);
		$display("block erase test done");
		op(FES_OP_CHIP_ERASE, 18'h0);
		rd(REG_STATUS);
		chk(st & 32'h6, 32'h2);
		chk(st & 32'h40, 32'h0);
		rd_flash(18'h3f000, 32'hffff);
		$display("chip erase test done");
		test_done;
	end
endmodule
